// ===== inc/ptp_pkg.sv
// constants, field layout and carrier types for the threshold programming block
// assumes a 250 MHz core clock; pin levels arrive as logic levels from comparators
package ptp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int ENTRY_LOW_MS = 1;
  localparam int WATCH_WIN_MS = 2;
  localparam int WORD_END_US = 200;
  localparam int COMM_END_US = 200;
  localparam int INT_CLK_NS = 1000;
  localparam int ENTRY_LOW_CYC = (ENTRY_LOW_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WATCH_WIN_CYC = (WATCH_WIN_MS * 1_000_000) / CLK_PERIOD_NS;
  localparam int WORD_END_CYC = (WORD_END_US * 1_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COMM_END_CYC = (COMM_END_US * 1_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;
  localparam logic [TICK_W-1:0] INT_CLK_CYC = TICK_W'(INT_CLK_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // widths and word layout
  // ----------------------------------------------------------------
  localparam int CNT_W = 20;
  localparam int THR_W = 8;
  localparam int KF_W = 3;
  localparam int WORD_W = 13;
  localparam int FRAME_W = 14;
  localparam int NB_W = 4;
  localparam int CP_W = 14;
  localparam logic [NB_W-1:0] FRAME_LEN = 4'hd;
  localparam logic [NB_W-1:0] FRAME_FULL = 4'he;
  localparam int HDR_LSB = 10;
  localparam logic [2:0] WORD1_HDR = 3'h5;
  localparam int KF_LSB = 1;
  localparam int INV_BIT = 0;
  localparam logic [WORD_W-1:0] WORD2_PAT = 13'h17ff;
  localparam logic [THR_W-1:0] SAR_FIRST = 8'h80;
  localparam logic [2:0] SAR_TOP = 3'h7;
  // switching-level factor in hundredths of a percent
  localparam logic [CP_W-1:0] KF_BASE_CP = 14'hcaa;
  localparam logic [CP_W-1:0] KF_STEP_CP = 14'h271;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTP_WATCH = 2'h0,
    PTP_TEST = 2'h1,
    PTP_RUN = 2'h3
  } ptp_mode_t;

  typedef struct packed {
    logic programmed;
    logic polarity;
    logic [KF_W-1:0] kfac;
    logic [THR_W-1:0] threshold;
  } ptp_cfg_t;

  typedef struct packed {
    logic supply_hi;
    logic out_low;
    logic field_above;
  } ptp_pins_t;

  localparam int PIN_W = $bits(ptp_pins_t);

endpackage : ptp_pkg

// ===== src/ptp_sync.sv
// two-stage synchroniser for a group of asynchronous levels
// assumes clk_en freezes it along with the rest of the block
`timescale 1ns/1ps
module ptp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else if (clk_en)
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : ptp_sync

// ===== src/ptp_prog.sv
// test-mode entry, supply-pin serial decoder and one-time threshold programming
// assumes supply and output pins come through comparators; fuse contents on otp_rd_i
// What the document requires
// R01: station holds output low 1 ms
// R02: copy command stores calibrated threshold permanently
// R03: station sends header word then fixed word
// R04: three-bit factor, msb first, fixed scale; block reads it lsb first from word bits 3:1
// R05: polarity bit zero inverts the output
// R06: long supply high ends test mode
// R07: test entry starts successive approximation on field
// R08: station waits ten internal clocks first
// R09: station sources programming current via output
// R10: lsb first, last fourteen pulses kept
// R11: pulse duty encodes bit, clocks output bit
// R12: programmed device refuses test mode entry
`timescale 1ns/1ps
module ptp_prog
  import ptp_pkg::*;
#(
  parameter int ENTRY_CYC = ENTRY_LOW_CYC,
  parameter int WATCH_CYC = WATCH_WIN_CYC,
  parameter int WORDEND_CYC = WORD_END_CYC,
  parameter int COMMEND_CYC = COMM_END_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic supply_hi_i,
  input wire logic out_pin_i,
  input wire logic field_above_i,
  input wire logic cal_done_i,
  input wire logic [THR_W-1:0] cal_thr_i,
  input wire ptp_cfg_t otp_rd_i,
  output logic out_pin_o,
  output logic out_pin_oe_b,
  output logic test_mode_o,
  output logic otp_wr_o,
  output ptp_cfg_t otp_wd_o,
  output logic [THR_W-1:0] dac_o,
  output logic sar_done_o,
  output logic [CP_W-1:0] kfac_cp_o
);

  localparam logic [CNT_W-1:0] ENTRY_L = ENTRY_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] WATCH_L = WATCH_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] WORDEND_L = WORDEND_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] COMMEND_L = COMMEND_CYC[CNT_W-1:0];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ptp_pins_t pins_raw;
  ptp_pins_t pins_s;

  assign pins_raw = {supply_hi_i, ~out_pin_i, field_above_i};

  ptp_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d(pins_raw),
    .q(pins_s)
  );

  // ----------------------------------------------------------------
  // mode: watch window, test mode, normal running
  // ----------------------------------------------------------------
  ptp_mode_t mode_reg, mode_next;
  logic [CNT_W-1:0] watch_reg, watch_next;
  logic [CNT_W-1:0] elow_reg, elow_next;
  logic in_test;
  logic enter_test;
  logic comm_end;

  always_comb
  begin
    mode_next = mode_reg;
    watch_next = watch_reg;
    elow_next = elow_reg;
    case (mode_reg)
      PTP_WATCH:
      begin
        watch_next = CNT_W'(watch_reg + 1'b1);
        elow_next = pins_s.out_low ? CNT_W'(elow_reg + 1'b1) : '0; // R01
        if (otp_rd_i.programmed)
          mode_next = PTP_RUN; // R12
        else if (elow_reg >= ENTRY_L)
          mode_next = PTP_TEST; // R01
        else if (watch_reg >= WATCH_L)
          mode_next = PTP_RUN;
      end
      PTP_TEST:
      begin
        if (comm_end)
          mode_next = PTP_RUN; // R06
      end
      PTP_RUN:
        mode_next = PTP_RUN;
      default:
        mode_next = PTP_WATCH;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_reg <= PTP_WATCH;
      watch_reg <= '0;
      elow_reg <= '0;
    end
    else if (clk_en)
    begin
      mode_reg <= mode_next;
      watch_reg <= watch_next;
      elow_reg <= elow_next;
    end
  end

  assign in_test = (mode_reg == PTP_TEST);
  assign enter_test = (mode_reg == PTP_WATCH) && (mode_next == PTP_TEST);

  // ----------------------------------------------------------------
  // serial link on the supply pin
  // ----------------------------------------------------------------
  logic sup_prev_reg, sup_prev_next;
  logic armed_reg, armed_next;
  logic [CNT_W-1:0] hi_reg, hi_next;
  logic [CNT_W-1:0] lo_reg, lo_next;
  logic [FRAME_W-1:0] sr_reg, sr_next;
  logic [NB_W-1:0] nb_reg, nb_next;
  logic [WORD_W-1:0] tx_reg, tx_next;
  logic [NB_W-1:0] txl_reg, txl_next;
  logic pend_reg, pend_next;
  logic [KF_W-1:0] pk_reg, pk_next;
  logic pi_reg, pi_next;
  logic wr_reg, wr_next;
  ptp_cfg_t wd_reg, wd_next;
  logic sup_rise, bit_pulse, word_end, push, bit_val;
  logic [WORD_W-1:0] word;
  logic [THR_W-1:0] copy_thr;
  logic copy_ok;

  assign sup_rise = pins_s.supply_hi && !sup_prev_reg;
  assign bit_pulse = in_test && sup_rise && armed_reg && (lo_reg < WORDEND_L); // R11
  assign word_end = in_test && armed_reg && !pins_s.supply_hi
                    && (lo_reg == CNT_W'(WORDEND_L - 1'b1)); // R10
  assign comm_end = in_test && armed_reg && pins_s.supply_hi
                    && (hi_reg == CNT_W'(COMMEND_L - 1'b1));
  assign push = bit_pulse || word_end;
  assign bit_val = (hi_reg > lo_reg); // R11
  assign word = sr_reg[FRAME_W-1:1];
  assign copy_ok = cal_done_i || sar_done_o;
  assign copy_thr = cal_done_i ? cal_thr_i : dac_o; // R02

  always_comb
  begin
    sup_prev_next = pins_s.supply_hi;
    armed_next = armed_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    sr_next = sr_reg;
    nb_next = nb_reg;
    tx_next = tx_reg;
    txl_next = txl_reg;
    pend_next = pend_reg;
    pk_next = pk_reg;
    pi_next = pi_reg;
    wr_next = 1'b0;
    wd_next = wd_reg;
    if (!in_test)
    begin
      armed_next = 1'b0;
      hi_next = '0;
      lo_next = '0;
      nb_next = '0;
      pend_next = 1'b0;
    end
    else if (sup_rise)
    begin
      armed_next = 1'b1;
      hi_next = CNT_W'(1);
      lo_next = '0;
    end
    else if (pins_s.supply_hi)
      hi_next = (hi_reg < COMMEND_L) ? CNT_W'(hi_reg + 1'b1) : hi_reg;
    else
      lo_next = (lo_reg < WORDEND_L) ? CNT_W'(lo_reg + 1'b1) : lo_reg;
    if (push)
    begin
      sr_next = {bit_val, sr_reg[FRAME_W-1:1]}; // R10
      nb_next = (nb_reg < FRAME_FULL) ? NB_W'(nb_reg + 1'b1) : nb_reg; // R10
      tx_next = {1'b1, tx_reg[WORD_W-1:1]}; // R11
      txl_next = (txl_reg != '0) ? NB_W'(txl_reg - 1'b1) : txl_reg; // R11
    end
    if (word_end)
    begin
      nb_next = '0;
      tx_next = otp_rd_i;
      txl_next = FRAME_LEN;
      if (nb_reg >= FRAME_LEN)
      begin
        if (pend_reg && (word == WORD2_PAT))
        begin
          pend_next = 1'b0;
          if (copy_ok && !otp_rd_i.programmed)
          begin
            wr_next = 1'b1; // R02
            wd_next = '{programmed: 1'b1, polarity: pi_reg, kfac: pk_reg, threshold: copy_thr};
          end
        end
        else if (word[WORD_W-1:HDR_LSB] == WORD1_HDR)
        begin
          pend_next = 1'b1;
          pk_next = word[KF_LSB +: KF_W]; // R04
          pi_next = word[INV_BIT]; // R05
        end
        else
          pend_next = 1'b0;
      end
    end
    if (enter_test)
    begin
      tx_next = otp_rd_i;
      txl_next = FRAME_LEN;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sup_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
      hi_reg <= '0;
      lo_reg <= '0;
      sr_reg <= '0;
      nb_reg <= '0;
      tx_reg <= '0;
      txl_reg <= '0;
      pend_reg <= 1'b0;
      pk_reg <= '0;
      pi_reg <= 1'b0;
      wr_reg <= 1'b0;
      wd_reg <= '0;
    end
    else if (clk_en)
    begin
      sup_prev_reg <= sup_prev_next;
      armed_reg <= armed_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      sr_reg <= sr_next;
      nb_reg <= nb_next;
      tx_reg <= tx_next;
      txl_reg <= txl_next;
      pend_reg <= pend_next;
      pk_reg <= pk_next;
      pi_reg <= pi_next;
      wr_reg <= wr_next;
      wd_reg <= wd_next;
    end
  end

  // ----------------------------------------------------------------
  // successive approximation of the offset converter
  // ----------------------------------------------------------------
  logic sbusy_reg, sbusy_next;
  logic sdone_reg, sdone_next;
  logic [2:0] sidx_reg, sidx_next;
  logic [TICK_W-1:0] tick_reg, tick_next;
  logic [THR_W-1:0] dac_reg, dac_next;

  always_comb
  begin
    sbusy_next = sbusy_reg;
    sdone_next = sdone_reg;
    sidx_next = sidx_reg;
    tick_next = tick_reg;
    dac_next = dac_reg;
    if (enter_test)
    begin
      sbusy_next = 1'b1; // R07
      sdone_next = 1'b0;
      sidx_next = SAR_TOP;
      tick_next = '0;
      dac_next = SAR_FIRST;
    end
    else if (sbusy_reg)
    begin
      if (tick_reg == TICK_W'(INT_CLK_CYC - 1'b1))
      begin
        tick_next = '0;
        if (!pins_s.field_above)
          dac_next[sidx_reg] = 1'b0; // R07
        if (sidx_reg == '0)
        begin
          sbusy_next = 1'b0;
          sdone_next = 1'b1;
        end
        else
        begin
          sidx_next = 3'(sidx_reg - 1'b1);
          dac_next[3'(sidx_reg - 1'b1)] = 1'b1;
        end
      end
      else
        tick_next = TICK_W'(tick_reg + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sbusy_reg <= 1'b0;
      sdone_reg <= 1'b0;
      sidx_reg <= '0;
      tick_reg <= '0;
      dac_reg <= '0;
    end
    else if (clk_en)
    begin
      sbusy_reg <= sbusy_next;
      sdone_reg <= sdone_next;
      sidx_reg <= sidx_next;
      tick_reg <= tick_next;
      dac_reg <= dac_next;
    end
  end

  // ----------------------------------------------------------------
  // output pin and factor
  // ----------------------------------------------------------------
  logic drv_reg, drv_next;
  logic [CP_W-1:0] kcp_reg, kcp_next;

  always_comb
  begin
    kcp_next = CP_W'(KF_BASE_CP + KF_STEP_CP * {{(CP_W-KF_W){1'b0}}, otp_rd_i.kfac}); // R04
    case (mode_reg)
      PTP_TEST:
        drv_next = (txl_reg != '0) && !tx_reg[0]; // R11
      PTP_RUN:
        drv_next = (otp_rd_i.programmed && !otp_rd_i.polarity)
                   ? !pins_s.field_above : pins_s.field_above; // R05
      default:
        drv_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drv_reg <= 1'b0;
      kcp_reg <= '0;
    end
    else if (clk_en)
    begin
      drv_reg <= drv_next;
      kcp_reg <= kcp_next;
    end
  end

  assign out_pin_o = 1'b0;
  assign out_pin_oe_b = !drv_reg;
  assign test_mode_o = in_test;
  assign otp_wr_o = wr_reg;
  assign otp_wd_o = wd_reg;
  assign dac_o = dac_reg;
  assign sar_done_o = sdone_reg;
  assign kfac_cp_o = kcp_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b || !clk_en);

  sequence s_entry;
    (mode_reg == PTP_WATCH) ##1 (mode_reg == PTP_TEST);
  endsequence

  a_refuse_entry: assert property ((mode_reg == PTP_WATCH) && otp_rd_i.programmed // R12
    |=> mode_reg == PTP_RUN) else $error("programmed device entered test mode");
  a_copy_value: assert property (word_end && cal_done_i && copy_ok && pend_reg // R02
    && !otp_rd_i.programmed && (nb_reg >= FRAME_LEN) && (word == WORD2_PAT)
    |=> otp_wr_o && (otp_wd_o.threshold == $past(cal_thr_i)))
    else $error("copy did not store calibrated threshold");
  a_kfac_scale: assert property (otp_rd_i.kfac == 3'h6 && $stable(otp_rd_i) // R04
    |=> kfac_cp_o == 14'h1b50) else $error("factor code 110 not 69.92 percent");
  a_out_polarity: assert property ((mode_reg == PTP_RUN) && otp_rd_i.programmed // R05
    && !otp_rd_i.polarity && pins_s.field_above |=> out_pin_oe_b)
    else $error("inverted output drove low above threshold");
  a_sar_start: assert property (s_entry |-> sbusy_reg && dac_o == SAR_FIRST) // R07
    else $error("approximation not started on test entry");
  a_frame_shift: assert property (push |=> sr_reg[FRAME_W-1] == $past(bit_val)) // R10
    else $error("received bit not shifted in at top");
  a_tx_step: assert property (push && !word_end && (txl_reg != '0) // R11
    |=> txl_reg == $past(txl_reg) - 1'b1) else $error("pulse did not clock out a bit");
  a_long_high: assert property (comm_end |=> mode_reg == PTP_RUN ##1 !test_mode_o) // R06
    else $error("long supply high did not leave test mode");

endmodule : ptp_prog

// ===== tb/ptp_station.sv
// programming station model: supply-pin serial link and output-pin pull-down
// assumes the bench resolves the open-drain output with a pull-up
`timescale 1ns/1ps
module ptp_station
#(
  parameter int WORD_END = 60,
  parameter int COMM_END = 80
) (
  input wire logic clk,
  output logic supply_hi,
  output logic pull_low
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial
  begin
    supply_hi = 1'b0;
    pull_low = 1'b0;
  end

  // ----------------------------------------------------------------
  // pin primitives
  // ----------------------------------------------------------------
  task automatic hold(input logic s, input int n);
    supply_hi <= s;
    repeat (n) @(posedge clk);
  endtask : hold

  // held low long enough starts test mode
  task automatic set_pull(input logic v);
    pull_low <= v;
  endtask : set_pull

  // ----------------------------------------------------------------
  // serial words, lsb first; last pulse ends with a long low
  // ----------------------------------------------------------------
  // output pin stays released here so the pull-up sources programming current
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      hold(1'b1, bits[i] ? 5 : 3);
      hold(1'b0, (i == n - 1) ? WORD_END : (bits[i] ? 3 : 5));
    end
  endtask : send

  // long high closes the session
  task automatic leave();
    hold(1'b1, COMM_END);
    hold(1'b0, 1);
  endtask : leave
endmodule : ptp_station

// ===== tb/ptp_prog_bench.sv
// self-checking bench for the threshold programming block
// assumes shortened counts and a behavioural fuse array fed by otp_wr_o
`timescale 1ns/1ps
module ptp_prog_bench;
  import ptp_pkg::*;
  localparam int E = 20;
  localparam int WE = 40;
  logic clk;
  logic rst_b;
  logic clk_en;
  logic field_above;
  logic cal_done;
  logic [THR_W-1:0] cal_thr;
  ptp_cfg_t fuse;
  logic out_pin_o;
  logic out_pin_oe_b;
  logic test_mode;
  logic otp_wr;
  ptp_cfg_t otp_wd;
  logic [THR_W-1:0] dac;
  logic sar_done;
  logic [CP_W-1:0] kfac_cp;
  logic supply_hi;
  logic pull_low;
  logic out_level;
  int errors;
  int tests_run;

`define CHK(nm, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

  // ----------------------------------------------------------------
  // clock, pin resolution, fuses
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #2 clk = ~clk;
  assign out_level = !(pull_low || !out_pin_oe_b);
  always @(posedge clk)
    if (otp_wr === 1'b1)
      fuse <= otp_wd;

  ptp_station st (
    .clk(clk), .supply_hi(supply_hi), .pull_low(pull_low));

  ptp_prog #(.ENTRY_CYC(E), .WATCH_CYC(200), .WORDEND_CYC(WE), .COMMEND_CYC(60)) dut (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .supply_hi_i(supply_hi),
    .out_pin_i(out_level), .field_above_i(field_above), .cal_done_i(cal_done),
    .cal_thr_i(cal_thr), .otp_rd_i(fuse), .out_pin_o(out_pin_o),
    .out_pin_oe_b(out_pin_oe_b), .test_mode_o(test_mode), .otp_wr_o(otp_wr),
    .otp_wd_o(otp_wd), .dac_o(dac), .sar_done_o(sar_done), .kfac_cp_o(kfac_cp));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic enter();
    st.set_pull(1'b1);
    repeat (E + 8) @(posedge clk);
    st.set_pull(1'b0);
  endtask : enter

  task automatic expect_write(input ptp_cfg_t exp);
    int i;
    i = 0;
    while (otp_wr !== 1'b1 && i < 400)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK("otp_wr", 1'b1, otp_wr)
    `CHK("otp_wd", exp, otp_wd)
    @(posedge clk);
    #1;
    `CHK("otp_wr_pulse", 1'b0, otp_wr)
  endtask : expect_write

  task automatic burn_words(input logic [2:0] k, input logic inv, input ptp_cfg_t exp,
                            input logic extra);
    logic [12:0] w1;
    w1 = {3'h5, 6'h00, k, inv};
    if (extra)
      st.send({1'b1, w1, 2'h3}, 16);
    else
      st.send({2'h0, 1'b1, w1}, 14);
    fork
      st.send({2'h0, 1'b1, WORD2_PAT}, 14);
      expect_write(exp);
    join
    st.leave();
    repeat (5) @(posedge clk);
    `CHK("test_mode_end", 1'b0, test_mode)
  endtask : burn_words

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    #1;
    `CHK("oe_b_rst", 1'b1, out_pin_oe_b)
    `CHK("test_rst", 1'b0, test_mode)
    `CHK("wr_rst", 1'b0, otp_wr)
    `CHK("dac_rst", 8'h00, dac)
    `CHK("sar_rst", 1'b0, sar_done)
    `CHK("pin_data", 1'b0, out_pin_o)
  endtask : t_reset_values

  task automatic t_short_low();
    do_reset();
    st.set_pull(1'b1);
    repeat (E - 5) @(posedge clk);
    st.set_pull(1'b0);
    repeat (E + 10) @(posedge clk);
    `CHK("short_low", 1'b0, test_mode)
  endtask : t_short_low

  task automatic t_static_field();
    do_reset();
    field_above <= 1'b1;
    st.set_pull(1'b1);
    repeat (E) @(posedge clk);
    #1;
    `CHK("entry_early", 1'b0, test_mode)
    repeat (5) @(posedge clk);
    #1;
    `CHK("entry", 1'b1, test_mode)
    `CHK("sar_start", 8'h80, dac)
    st.set_pull(1'b0);
    // frozen block must not step the approximation
    clk_en <= 1'b0;
    repeat (300) @(posedge clk);
    #1;
    `CHK("freeze_dac", 8'h80, dac)
    `CHK("freeze_mode", 1'b1, test_mode)
    clk_en <= 1'b1;
    repeat (2600) @(posedge clk);
    `CHK("sar_done", 1'b1, sar_done)
    `CHK("sar_value", 8'hff, dac)
    burn_words(3'h6, 1'b0, {1'b1, 1'b0, 3'h6, 8'hff}, 1'b1);
  endtask : t_static_field

  task automatic t_run_output();
    repeat (4) @(posedge clk);
    `CHK("kfac_hi", 14'h1b50, kfac_cp)
    field_above <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("inv_below", 1'b0, out_pin_oe_b)
    field_above <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("inv_above", 1'b1, out_pin_oe_b)
  endtask : t_run_output

  task automatic t_locked();
    do_reset();
    st.set_pull(1'b1);
    repeat (E + 20) @(posedge clk);
    `CHK("locked", 1'b0, test_mode)
    st.set_pull(1'b0);
  endtask : t_locked

  task automatic t_calibrated();
    fuse <= '0;
    cal_done <= 1'b1;
    cal_thr <= 8'h5a;
    do_reset();
    enter();
    `CHK("cal_entry", 1'b1, test_mode)
    `CHK("readback_bit0", 1'b0, out_pin_oe_b)
    repeat (20) @(posedge clk);
    burn_words(3'h3, 1'b1, {1'b1, 1'b1, 3'h3, 8'h5a}, 1'b0);
    repeat (4) @(posedge clk);
    `CHK("kfac_lo", 14'h13fd, kfac_cp)
    `CHK("norm_above", 1'b0, out_pin_oe_b)
    field_above <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("norm_below", 1'b1, out_pin_oe_b)
  endtask : t_calibrated

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    field_above = 1'b0;
    cal_done = 1'b0;
    cal_thr = 8'h00;
    fuse = '0;
    repeat (6) @(posedge clk);
    t_reset_values();
    t_short_low();
    t_static_field();
    t_run_output();
    t_locked();
    t_calibrated();
    conclude();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : ptp_prog_bench
